// ### bench/icsr_host.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Channel host that issues commands and data transfers
// ----------------------------------------------------------------------
module icsr_host (
  // Clock.
  input  wire logic        clk_i,
  // Slave answer.
  input  wire logic        wait_i,
  input  wire logic [31:0] rdata_i,
  // Request.
  output logic      [4:0]  addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [3:0]  be_o,
  output logic      [31:0] wdata_o
);
  initial begin
    addr_o  = 5'h00;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    be_o    = 4'h1;
    wdata_o = 32'h00000000;
  end

  // The request is held until the slave accepts it, however long it stalls.
  task automatic xfer(input logic we, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    rd_o    <= !we;
    wr_o    <= we;
    do @(posedge clk_i); while (wait_i !== 1'b0);
    q = rdata_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
  endtask
endmodule

// ### bench/test_interval_clock_snapshot_restart.sv
`timescale 1ns/100ps
`include "icsr_cfg.svh"

module test_interval_clock_snapshot_restart;
  import icsr_pkg::*;

  logic        ref_clk;
  logic        rst_n;
  logic        ce;
  logic [4:0]  addr;
  logic        rd_s;
  logic        wr_s;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_s;
  logic        irq;
  logic [31:0] q;
  logic [31:0] e;
  logic [31:0] lfsr;
  int          err_count;
  int          checks;
  icsr_count_t m_count;
  logic [7:0]  m_cap[$];

  icsr_top uut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .clk_en_i(ce),
    .avs_address_i(addr), .avs_read_i(rd_s), .avs_write_i(wr_s),
    .avs_byteenable_i(be), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_s), .irq_o(irq));

  icsr_host host (.clk_i(ref_clk), .wait_i(wait_s), .rdata_i(rdata), .addr_o(addr),
    .rd_o(rd_s), .wr_o(wr_s), .be_o(be), .wdata_o(wdata));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, x);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask

  // Preset bytes go most significant first; bytes not sent read as zero.
  task automatic load(input logic [7:0] c, input int n, input logic [23:0] v);
    logic [7:0] b;
    wr(`ICSR_OFF_CMD, {24'h0, c});
    m_count = 24'h000000;
    for (int i = 0; i < n; i++) begin
      b = 8'(v >> (8 * (n - 1 - i)));
      wr(`ICSR_OFF_DATA, {24'h0, b});
      m_count = {m_count[15:0], b};
    end
  endtask

  task automatic snap(input logic [7:0] c);
    wr(`ICSR_OFF_CMD, {24'h0, c});
    m_cap = {m_count[23:16], m_count[15:8], m_count[7:0]};
  endtask

  task automatic rdd();
    rd(`ICSR_OFF_DATA);
    e = (m_cap.size() != 0) ? {24'h0, m_cap.pop_front()} : 32'h0;
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 4000 && irq !== 1'b1; i++)
      @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    err_count = 0;
    checks = 0;
    lfsr = 32'd95650;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`ICSR_OFF_STAT);
    chk(q, 32'h1);
    rd(`ICSR_OFF_IRQ_MASK);
    chk(q, 32'h0);
    rd(5'h18);
    chk(q, 32'h0);
    // Random three-byte preset, then a capture with the counter held.
    load(8'h5c, 3, 24'(next_rand()));
    rd(`ICSR_OFF_COUNT);
    chk(q, {8'h0, m_count});
    rd(`ICSR_OFF_IRQ_ST);
    chk(q, 32'h2);
    wr(`ICSR_OFF_IRQ_ST, 32'h3);
    snap(8'h20);
    rd(`ICSR_OFF_CMD);
    chk(q & 32'hf, 32'hc);
    for (int i = 0; i < 4; i++) begin
      rdd();
      chk(q, e);
    end
    // A second capture in mid readout starts again at the top byte.
    snap(8'h20);
    rdd();
    chk(q, e);
    snap(8'h20);
    for (int i = 0; i < 3; i++) begin
      rdd();
      chk(q, e);
    end
    wr(`ICSR_OFF_CMD, 32'h13);
    rd(`ICSR_OFF_CMD);
    chk(q & 32'hf, 32'h3);
    // One-byte preset clears the upper bytes and stays put while held.
    load(8'h54, 1, 24'(next_rand()));
    repeat (2500) @(posedge ref_clk);
    rd(`ICSR_OFF_COUNT);
    chk(q, {8'h0, m_count});
    // Auto-restart: run, capture in flight, zero interrupt, reload.
    load(8'h55, 1, 24'h000003);
    wr(`ICSR_OFF_IRQ_MASK, 32'h1);
    wr(`ICSR_OFF_CMD, 32'ha0);
    for (int i = 0; i < 2; i++) begin
      rd(`ICSR_OFF_DATA);
      chk(q, 32'h0);
    end
    wait_irq();
    chk({31'h0, irq}, 32'h1);
    rd(`ICSR_OFF_COUNT);
    chk(q, 32'h3);
    // With the clock enable low the timebase and the count stay frozen.
    ce <= 1'b0;
    repeat (1500) @(posedge ref_clk);
    ce <= 1'b1;
    rd(`ICSR_OFF_COUNT);
    chk(q, 32'h3);
    wr(`ICSR_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rd(`ICSR_OFF_IRQ_ST);
    chk(q & 32'h1, 32'h1);
    // Capture at count one with restart off; the zero event ends capture.
    load(8'h57, 1, 24'h000001);
    wr(`ICSR_OFF_IRQ_ST, 32'h3);
    rd(`ICSR_OFF_IRQ_ST);
    chk(q, 32'h0);
    wr(`ICSR_OFF_IRQ_MASK, 32'h1);
    snap(8'ha0);
    rdd();
    chk(q, e);
    wait_irq();
    chk({31'h0, irq}, 32'h1);
    m_cap.delete();
    rdd();
    chk(q, e);
    rd(`ICSR_OFF_COUNT);
    chk(q, 32'h0);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    close_out();
  end
endmodule

// ### rtl/icsr_cap_if.sv
`timescale 1ns/100ps

interface icsr_cap_if;
  import icsr_pkg::*;

  logic        cap_start;
  logic        zero_evt;
  logic        rd_take;
  icsr_count_t count;
  logic        active;
  logic [7:0]  rd_byte;

  modport ctl (output cap_start, output zero_evt, output rd_take, output count,
               input active, input rd_byte);
  modport cap (input cap_start, input zero_evt, input rd_take, input count,
               output active, output rd_byte);
endinterface

// ### rtl/icsr_cfg.svh
`ifndef ICSR_CFG_SVH
`define ICSR_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ICSR_OFF_CMD        5'h00
`define ICSR_OFF_DATA       5'h04
`define ICSR_OFF_STAT       5'h08
`define ICSR_OFF_COUNT      5'h0c
`define ICSR_OFF_IRQ_ST     5'h10
`define ICSR_OFF_IRQ_MASK   5'h14

// ----------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------
`define ICSR_CMD_RUN        7
`define ICSR_CMD_LOAD       6
`define ICSR_CMD_SNAP       5
`define ICSR_CMD_SAMPLE     4
`define ICSR_CMD_BC_HI      3
`define ICSR_CMD_BC_LO      2
`define ICSR_CMD_RESTART_N  1
`define ICSR_CMD_INT_EN     0
`define ICSR_CMD_LOW_HI     3

// ----------------------------------------------------------------------
// Status and interrupt fields
// ----------------------------------------------------------------------
`define ICSR_STAT_ONLINE    0
`define ICSR_STAT_SNAP      1
`define ICSR_STAT_LOADING   2
`define ICSR_STAT_RUN       3
`define ICSR_IRQ_ZERO       0
`define ICSR_IRQ_LOAD       1

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define ICSR_RESET_CMD      8'h00
`define ICSR_RESET_COUNT    24'h000000
`define ICSR_RESET_IRQ      2'h0
`define ICSR_LAST_BYTE      2'h2
`define ICSR_CLK_PERIOD_NS  10
`define ICSR_TICK_PERIOD_NS 10000
`define ICSR_TICK_CYCLES    (`ICSR_TICK_PERIOD_NS / `ICSR_CLK_PERIOD_NS)

`endif

// ### rtl/icsr_pkg.sv
package icsr_pkg;

  typedef logic [23:0] icsr_count_t;
  typedef logic [1:0]  icsr_byte_idx_t;
  typedef logic [9:0]  icsr_tick_cnt_t;

  typedef enum logic {
    ICSR_LD_IDLE  = 1'b0,
    ICSR_LD_BYTES = 1'b1
  } icsr_load_t;

endpackage

// ### rtl/icsr_snap.sv
`timescale 1ns/100ps
`include "icsr_cfg.svh"

module icsr_snap
  import icsr_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Capture link to the controller.
  icsr_cap_if.cap   cap
);

  icsr_count_t    hold_reg;
  icsr_byte_idx_t idx_reg;
  logic           active_reg;

  // ----------------------------------------------------------------------
  // Capture register and byte readout
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_reg   <= `ICSR_RESET_COUNT;
      idx_reg    <= '0;
      active_reg <= 1'b0;
    end else if (ce_i) begin
      if (cap.cap_start) begin
        hold_reg   <= cap.count;
        idx_reg    <= '0;
        active_reg <= 1'b1;
      end else if (cap.zero_evt && active_reg) begin
        active_reg <= 1'b0;
      end else if (cap.rd_take && active_reg) begin
        idx_reg <= idx_reg + icsr_byte_idx_t'(1);
        if (idx_reg == `ICSR_LAST_BYTE) begin
          active_reg <= 1'b0;
        end
      end
    end
  end

  // Most significant byte is offered first; idle readout gives zero.
  always_comb begin
    cap.rd_byte = 8'h00;
    if (active_reg) begin
      unique case (idx_reg)
        2'h0:    cap.rd_byte = hold_reg[23:16];
        2'h1:    cap.rd_byte = hold_reg[15:8];
        2'h2:    cap.rd_byte = hold_reg[7:0];
        default: cap.rd_byte = 8'h00;
      endcase
    end
  end

  assign cap.active = active_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_cap_copy;
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && cap.cap_start) |=> (hold_reg == $past(cap.count)) && active_reg && idx_reg == 2'h0;
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture did not copy count");

  property p_zero_ends;
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && active_reg && cap.zero_evt && !cap.cap_start) |=> !active_reg;
  endproperty
  a_zero_ends: assert property (p_zero_ends) else $error("zero did not end capture");

  property p_three_bytes;
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && active_reg && cap.rd_take && idx_reg == 2'h2 && !cap.cap_start && !cap.zero_evt)
      |=> !active_reg;
  endproperty
  a_three_bytes: assert property (p_three_bytes) else $error("readout not three bytes");

  c_readout: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cap.cap_start ##[1:50] (cap.rd_take && idx_reg == 2'h2));

endmodule

// ### rtl/icsr_tick.sv
`timescale 1ns/100ps
`include "icsr_cfg.svh"

module icsr_tick
  import icsr_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Timebase pulse.
  output logic      tick_o
);

  icsr_tick_cnt_t div_reg;

  // ----------------------------------------------------------------------
  // Free-running divider for the counting timebase
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= '0;
      tick_o  <= 1'b0;
    end else if (ce_i) begin
      if (div_reg == icsr_tick_cnt_t'(`ICSR_TICK_CYCLES - 1)) begin
        div_reg <= '0;
        tick_o  <= 1'b1;
      end else begin
        div_reg <= div_reg + icsr_tick_cnt_t'(1);
        tick_o  <= 1'b0;
      end
    end
  end

endmodule

// ### rtl/icsr_top.sv
`timescale 1ns/100ps
`include "icsr_cfg.svh"

module icsr_top
  import icsr_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // Avalon-MM slave.
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Interrupt.
  output logic             irq_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic           rst_meta_reg;
  logic           rst_sync_reg;
  logic           rst_n;
  logic           tick;
  logic           req;
  logic           accept;
  logic           wr_acc;
  logic           rd_acc;
  logic           wr_cmd;
  logic           wr_data;
  logic [7:0]     wbyte;
  logic [7:0]     cmd_reg;
  logic [7:0]     cmd_next;
  icsr_count_t    count_reg;
  icsr_count_t    preset_reg;
  icsr_load_t     load_reg;
  icsr_byte_idx_t left_reg;
  logic           zero_evt_reg;
  logic           load_done;
  logic [1:0]     irq_st_reg;
  logic [1:0]     irq_mask_reg;
  logic [1:0]     irq_set;
  logic [31:0]    rd_mux;
  logic           counting;

  icsr_cap_if cap_if ();

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    return addr == off;
  endfunction

  function automatic icsr_count_t shift_in(input icsr_count_t v, input logic [7:0] b);
    return {v[15:0], b};
  endfunction

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  assign req     = avs_read_i | avs_write_i;
  assign accept  = req & ~avs_waitrequest_o;
  assign wr_acc  = accept & avs_write_i & avs_byteenable_i[0];
  assign rd_acc  = accept & avs_read_i;
  assign wbyte   = avs_writedata_i[7:0];
  assign wr_cmd  = wr_acc & hit(avs_address_i, `ICSR_OFF_CMD);
  assign wr_data = wr_acc & hit(avs_address_i, `ICSR_OFF_DATA);

  // Each request is held off one cycle, then accepted for one cycle.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
    end else if (clk_en_i) begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_address_i, `ICSR_OFF_CMD)) begin
      rd_mux[7:0] = cmd_reg;
    end else if (hit(avs_address_i, `ICSR_OFF_DATA)) begin
      rd_mux[7:0] = cap_if.rd_byte;
    end else if (hit(avs_address_i, `ICSR_OFF_STAT)) begin
      rd_mux[`ICSR_STAT_ONLINE]  = 1'b1;
      rd_mux[`ICSR_STAT_SNAP]    = cap_if.active;
      rd_mux[`ICSR_STAT_LOADING] = (load_reg == ICSR_LD_BYTES);
      rd_mux[`ICSR_STAT_RUN]     = cmd_reg[`ICSR_CMD_RUN];
    end else if (hit(avs_address_i, `ICSR_OFF_COUNT)) begin
      rd_mux[23:0] = count_reg;
    end else if (hit(avs_address_i, `ICSR_OFF_IRQ_ST)) begin
      rd_mux[1:0] = irq_st_reg;
    end else if (hit(avs_address_i, `ICSR_OFF_IRQ_MASK)) begin
      rd_mux[1:0] = irq_mask_reg;
    end
  end

  // Read data is captured in the wait cycle and stands at acceptance.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (clk_en_i && avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Command word
  // ----------------------------------------------------------------------
  always_comb begin
    cmd_next = cmd_reg;
    if (wr_cmd) begin
      cmd_next[7:4] = wbyte[7:4];
      if (wbyte[`ICSR_CMD_SAMPLE]) begin
        cmd_next[`ICSR_CMD_LOW_HI:0] = wbyte[`ICSR_CMD_LOW_HI:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= `ICSR_RESET_CMD;
    end else if (clk_en_i) begin
      cmd_reg <= cmd_next;
    end
  end

  // ----------------------------------------------------------------------
  // Preset loading
  // ----------------------------------------------------------------------
  assign load_done = wr_data && (load_reg == ICSR_LD_BYTES) && (left_reg == 2'h1);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      load_reg   <= ICSR_LD_IDLE;
      left_reg   <= '0;
      preset_reg <= `ICSR_RESET_COUNT;
    end else if (clk_en_i) begin
      if (wr_cmd && wbyte[`ICSR_CMD_LOAD]) begin
        preset_reg <= `ICSR_RESET_COUNT;
        left_reg   <= cmd_next[`ICSR_CMD_BC_HI:`ICSR_CMD_BC_LO];
        load_reg   <= (cmd_next[`ICSR_CMD_BC_HI:`ICSR_CMD_BC_LO] == 2'h0) ?
                      ICSR_LD_IDLE : ICSR_LD_BYTES;
      end else if (wr_data && (load_reg == ICSR_LD_BYTES)) begin
        preset_reg <= shift_in(preset_reg, wbyte);
        left_reg   <= left_reg - icsr_byte_idx_t'(1);
        if (left_reg == 2'h1) begin
          load_reg <= ICSR_LD_IDLE;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------------
  icsr_tick u_tick (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .ce_i    (clk_en_i),
    .tick_o  (tick)
  );

  assign counting = cmd_reg[`ICSR_CMD_RUN] && (load_reg == ICSR_LD_IDLE);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count_reg    <= `ICSR_RESET_COUNT;
      zero_evt_reg <= 1'b0;
    end else if (clk_en_i) begin
      zero_evt_reg <= 1'b0;
      if (wr_cmd && wbyte[`ICSR_CMD_LOAD]) begin
        count_reg <= `ICSR_RESET_COUNT;
      end else if (wr_data && (load_reg == ICSR_LD_BYTES)) begin
        count_reg <= shift_in(preset_reg, wbyte);
      end else if (zero_evt_reg && !cmd_reg[`ICSR_CMD_RESTART_N]) begin
        count_reg <= preset_reg;
      end else if (tick && counting && (count_reg != `ICSR_RESET_COUNT)) begin
        count_reg <= count_reg - icsr_count_t'(1);
        if (count_reg == icsr_count_t'(1)) begin
          zero_evt_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Capture link
  // ----------------------------------------------------------------------
  assign cap_if.cap_start = wr_cmd && wbyte[`ICSR_CMD_SNAP];
  assign cap_if.zero_evt  = zero_evt_reg;
  assign cap_if.rd_take   = rd_acc && hit(avs_address_i, `ICSR_OFF_DATA);
  assign cap_if.count     = count_reg;

  icsr_snap u_snap (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .ce_i    (clk_en_i),
    .cap     (cap_if)
  );

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    irq_set                 = `ICSR_RESET_IRQ;
    irq_set[`ICSR_IRQ_ZERO] = zero_evt_reg && cmd_reg[`ICSR_CMD_INT_EN];
    irq_set[`ICSR_IRQ_LOAD] = load_done;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_reg   <= `ICSR_RESET_IRQ;
      irq_mask_reg <= `ICSR_RESET_IRQ;
      irq_o        <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_acc && hit(avs_address_i, `ICSR_OFF_IRQ_ST)) begin
        irq_st_reg <= (irq_st_reg & ~avs_writedata_i[1:0]) | irq_set;
      end else begin
        irq_st_reg <= irq_st_reg | irq_set;
      end
      if (wr_acc && hit(avs_address_i, `ICSR_OFF_IRQ_MASK)) begin
        irq_mask_reg <= avs_writedata_i[1:0];
      end
      irq_o <= |(irq_st_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_restart;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && zero_evt_reg && !cmd_reg[`ICSR_CMD_RESTART_N] && !wr_acc)
      |=> count_reg == $past(preset_reg);
  endproperty
  a_restart: assert property (p_restart) else $error("no reload after zero");

  property p_hold_at_zero;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && zero_evt_reg && cmd_reg[`ICSR_CMD_RESTART_N] && !wr_acc)
      |=> count_reg == 24'h000000;
  endproperty
  a_hold_at_zero: assert property (p_hold_at_zero) else $error("restart with bit 1 set");

  property p_held;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && !cmd_reg[`ICSR_CMD_RUN] && !wr_acc && !zero_evt_reg) |=> $stable(count_reg);
  endproperty
  a_held: assert property (p_held) else $error("count moved while held");

  property p_decrement;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && tick && counting && !wr_acc && !zero_evt_reg && count_reg > 24'h000001)
      |=> count_reg == $past(count_reg) - 24'h000001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("missed decrement");

  property p_tick_spacing;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && tick) |=> !tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");

  property p_irq_cause;
    @(posedge ref_clk_i) disable iff (!rst_n)
    $rose(irq_st_reg[`ICSR_IRQ_ZERO]) |-> $past(zero_evt_reg && cmd_reg[`ICSR_CMD_INT_EN]);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("zero irq without enable");

  property p_irq_set;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && zero_evt_reg && cmd_reg[`ICSR_CMD_INT_EN]) |=> irq_st_reg[`ICSR_IRQ_ZERO];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("zero irq lost");

  property p_sample;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && wr_cmd && !wbyte[`ICSR_CMD_SAMPLE]) |=> $stable(cmd_reg[3:0]);
  endproperty
  a_sample: assert property (p_sample) else $error("low bits changed unsampled");

  property p_load_shift;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && wr_data && load_reg == ICSR_LD_BYTES)
      |=> preset_reg == {$past(preset_reg[15:0]), $past(wbyte)};
  endproperty
  a_load_shift: assert property (p_load_shift) else $error("preset byte order wrong");

  property p_run_capture;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && cap_if.rd_take && counting && !zero_evt_reg && count_reg > 24'h000001)
      |=> count_reg == ($past(tick) ? $past(count_reg) - 24'h000001 : $past(count_reg));
  endproperty
  a_run_capture: assert property (p_run_capture) else $error("readout disturbed count");

  c_restart: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    zero_evt_reg && !cmd_reg[`ICSR_CMD_RESTART_N]);
  c_load: cover property (@(posedge ref_clk_i) disable iff (!rst_n) load_done);
  c_irq: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $rose(irq_o));

endmodule
